/* File: tma_clk_div.sv */
// Divider that gives a one-cycle enable every period of source enables
`timescale 1ns/1ps
module tma_clk_div #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic src_en_i,
  input wire logic [WIDTH-1:0] period_i,
  output logic tick_o
);
  logic [WIDTH-1:0] cnt;
  logic [WIDTH-1:0] next_cnt;
  logic next_tick;

  always_comb begin
    next_cnt = cnt;
    next_tick = 1'b0;
    if (src_en_i) begin
      if (period_i <= {{(WIDTH-1){1'b0}}, 1'b1} || cnt >= period_i - 1'b1) begin
        next_cnt = '0;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick_o <= next_tick;
    end
  end
endmodule

/* File: tma_defs.svh */
// Constants for the timer channel: field codes, reset values and divider figures
`ifndef TMA_DEFS_SVH
`define TMA_DEFS_SVH
`define TMA_MODE_TIMER 2'h0
`define TMA_MODE_EVENT 2'h1
`define TMA_MODE_ONESHOT 2'h2
`define TMA_MODE_PWM 2'h3
`define TMA_SRC_UNDIV 2'h0
`define TMA_SRC_DIV8 2'h1
`define TMA_SRC_PRESC 2'h2
`define TMA_SRC_SUB32 2'h3
`define TMA_EVT_PIN 2'h0
`define TMA_EVT_OTHER_GROUP 2'h1
`define TMA_EVT_PREV 2'h2
`define TMA_EVT_NEXT 2'h3
`define TMA_CNT_ZERO 16'h0000
`define TMA_CNT_ONES 16'hFFFF
`define TMA_DIV8_COUNT 16'h0008
`define TMA_SUB_DIV_COUNT 16'h0020
`endif

/* File: tma_edge_det.sv */
// Edge detector that flags the chosen edge of a synchronous input
`timescale 1ns/1ps
module tma_edge_det (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic sig_i,
  input wire logic fall_i,
  output logic edge_o
);
  logic prev;
  logic next_prev;
  logic primed;
  logic next_primed;

  always_comb begin
    next_prev = sig_i;
    next_primed = 1'b1;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev <= 1'b0;
      primed <= 1'b0;
    end else begin
      prev <= next_prev;
      primed <= next_primed;
    end
  end

  // No edge until the pin has been sampled once, so a high pin at reset is not an edge
  assign edge_o = primed && (fall_i ? (prev & ~sig_i) : (~prev & sig_i));
endmodule

/* File: tma_neighbour_model.sv */
// Model of the neighbouring and other-group timers giving wrap pulses
`timescale 1ns/1ps
module tma_neighbour_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic fire_i,
  input wire logic [1:0] which_i,
  output logic other_group_event_o,
  output logic prev_channel_event_o,
  output logic next_channel_event_o
);
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {other_group_event_o, prev_channel_event_o, next_channel_event_o} <= 3'h0;
    end else begin
      other_group_event_o <= fire_i && which_i == 2'h1;
      prev_channel_event_o <= fire_i && which_i == 2'h2;
      next_channel_event_o <= fire_i && which_i == 2'h3;
    end
  end
endmodule

/* File: tma_pkg.sv */
// Types shared by the timer channel modules
package tma_pkg;
  typedef enum logic [1:0] {
    TMA_TIMER,
    TMA_EVENT,
    TMA_ONESHOT,
    TMA_PWM
  } tma_mode_t;
endpackage

/* File: tma_timer_channel.sv */
// One sixteen-bit reloadable timer channel with timer and event counter modes
// Overview of operation
// RULE_01 - Timer mode counts one selected internal source
// RULE_02 - Timer mode decrements, reloads on underflow
// RULE_03 - Decrement divides source by value plus one
// RULE_04 - Channel counts only while run flag set
// RULE_05 - Timer mode interrupts on each underflow
// RULE_06 - Count read returns the live counter
// RULE_07 - Stopped write loads both; running, reload only
// RULE_08 - Gate pin level enables counting when enabled
// RULE_09 - Timer mode pulse output toggles on underflow
// RULE_10 - Prescaler zero undivided, else divide by 2n
// RULE_11 - Event mode counts pin edge, edge selectable
// RULE_12 - Events from other group, previous, next channel
// RULE_13 - Direction from software or output pin level
// RULE_14 - Event mode reloads on overflow or underflow
// RULE_15 - Free-running mode wraps without reload
// RULE_16 - Increment divides by ones minus value plus one
// RULE_17 - Event mode interrupts on overflow or underflow
// RULE_18 - Event mode pulse output toggles on both
// RULE_19 - Counter and reload are sixteen bits
// RULE_20 - Two-bit operating mode field selects mode
// RULE_21 - Zero count value: no start, no interrupt
// RULE_22 - Interrupt is one pulse with the event
`timescale 1ns/1ps
`include "tma_defs.svh"
module tma_timer_channel #(
  parameter int WIDTH = 16,
  parameter int PRESC_WIDTH = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic channel_run_flag_i,
  input wire logic [1:0] operating_mode_field_i,
  input wire logic [1:0] count_source_sel_i,
  input wire logic [PRESC_WIDTH-1:0] prescale_divide_field_i,
  input wire logic subclock_tick_i,
  input wire logic gate_enable_i,
  input wire logic gate_active_high_i,
  input wire logic pulse_output_enable_i,
  input wire logic [1:0] event_source_sel_i,
  input wire logic event_falling_edge_i,
  input wire logic other_group_event_i,
  input wire logic prev_channel_event_i,
  input wire logic next_channel_event_i,
  input wire logic direction_from_pin_i,
  input wire logic count_up_i,
  input wire logic free_running_i,
  input wire logic timer_input_pin_i,
  input wire logic timer_output_pin_i,
  input wire logic count_write_i,
  input wire logic [WIDTH-1:0] count_write_data_i,
  output logic [WIDTH-1:0] count_read_data_o,
  output logic [WIDTH-1:0] reload_value_o,
  output logic timer_output_pin_o,
  output logic timer_output_pin_oe_o,
  output logic wrap_event_o,
  output logic irq_o
);
  tma_pkg::tma_mode_t mode;
  logic [WIDTH-1:0] counter;
  logic [WIDTH-1:0] reload;
  logic out_level;
  logic irq;
  logic [WIDTH-1:0] next_counter;
  logic [WIDTH-1:0] next_reload;
  logic next_out_level;
  logic next_irq;
  logic div8_tick;
  logic presc_tick;
  logic sub32_tick;
  logic [WIDTH-1:0] presc_period;
  logic pin_edge;
  logic source_tick;
  logic event_tick;
  logic gate_open;
  logic step;
  logic count_up;
  logic at_limit;
  logic running;
  logic event_mode;
  logic free_wrap;
  logic limit_step;
  logic plain_step;
  logic stopped_write;
  logic [WIDTH-1:0] wrap_value;
  logic [WIDTH-1:0] stepped_value;
  logic irq_allowed;
  logic toggle_due;

  assign mode = tma_pkg::tma_mode_t'(operating_mode_field_i); // [RULE_20]
  assign event_mode = (mode == tma_pkg::TMA_EVENT);

  // Divided prescaler: zero passes the clock through, n divides by 2n
  always_comb begin
    if (prescale_divide_field_i == '0) begin
      presc_period = `TMA_CNT_ZERO; // [RULE_10]
    end else begin
      presc_period = {{(WIDTH-PRESC_WIDTH-1){1'b0}}, prescale_divide_field_i, 1'b0};
    end
  end

  tma_clk_div #(.WIDTH(WIDTH)) u_div8 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .src_en_i(1'b1),
    .period_i(`TMA_DIV8_COUNT),
    .tick_o(div8_tick)
  );

  tma_clk_div #(.WIDTH(WIDTH)) u_presc (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .src_en_i(1'b1),
    .period_i(presc_period),
    .tick_o(presc_tick)
  );

  tma_clk_div #(.WIDTH(WIDTH)) u_sub32 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .src_en_i(subclock_tick_i),
    .period_i(`TMA_SUB_DIV_COUNT),
    .tick_o(sub32_tick)
  );

  tma_edge_det u_pin_edge (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .sig_i(timer_input_pin_i),
    .fall_i(event_falling_edge_i),
    .edge_o(pin_edge)
  );

  always_comb begin
    case (count_source_sel_i) // [RULE_01]
      `TMA_SRC_UNDIV: source_tick = 1'b1;
      `TMA_SRC_DIV8: source_tick = div8_tick;
      `TMA_SRC_PRESC: source_tick = presc_tick;
      `TMA_SRC_SUB32: source_tick = sub32_tick;
      default: source_tick = 1'b0;
    endcase
  end

  always_comb begin
    case (event_source_sel_i)
      `TMA_EVT_PIN: event_tick = pin_edge; // [RULE_11]
      `TMA_EVT_OTHER_GROUP: event_tick = other_group_event_i; // [RULE_12]
      `TMA_EVT_PREV: event_tick = prev_channel_event_i; // [RULE_12]
      `TMA_EVT_NEXT: event_tick = next_channel_event_i; // [RULE_12]
      default: event_tick = 1'b0;
    endcase
  end

  // Gate holds the count while the input pin is at its inactive level
  always_comb begin
    gate_open = 1'b1;
    if (gate_enable_i) begin
      gate_open = (timer_input_pin_i == gate_active_high_i); // [RULE_08]
    end
  end

  // A zero count keeps the channel idle
  assign running = channel_run_flag_i && (counter != `TMA_CNT_ZERO ||
    reload != `TMA_CNT_ZERO); // [RULE_04] [RULE_21]

  // Timer mode only counts down; event mode takes software or pin direction
  always_comb begin
    count_up = 1'b0; // [RULE_02]
    if (event_mode) begin
      if (direction_from_pin_i) begin
        count_up = timer_output_pin_i; // [RULE_13]
      end else begin
        count_up = count_up_i; // [RULE_13]
      end
    end
  end

  always_comb begin
    case (mode)
      tma_pkg::TMA_TIMER: step = running && source_tick && gate_open;
      tma_pkg::TMA_EVENT: step = running && event_tick;
      default: step = 1'b0;
    endcase
  end

  // Underflow after zero gives n+1 steps; overflow after all-ones gives ones-n+1
  always_comb begin
    if (count_up) begin
      at_limit = (counter == `TMA_CNT_ONES); // [RULE_16]
    end else begin
      at_limit = (counter == `TMA_CNT_ZERO); // [RULE_03]
    end
  end

  // Qualified events of this cycle
  assign limit_step = step && at_limit;
  assign plain_step = step && !at_limit;
  assign free_wrap = event_mode && free_running_i; // [RULE_15]
  assign stopped_write = count_write_i && !channel_run_flag_i; // [RULE_07]
  assign irq_allowed = (reload != `TMA_CNT_ZERO) || free_wrap; // [RULE_21]
  assign toggle_due = limit_step && pulse_output_enable_i; // [RULE_09] [RULE_18]

  // Free-running wrap lands on the opposite limit
  always_comb begin
    if (count_up) begin
      wrap_value = `TMA_CNT_ZERO;
    end else begin
      wrap_value = `TMA_CNT_ONES;
    end
  end

  always_comb begin
    if (count_up) begin
      stepped_value = counter + 1'b1;
    end else begin
      stepped_value = counter - 1'b1;
    end
  end

  // Counter: a stopped write overrides any step
  always_comb begin
    next_counter = counter;
    if (limit_step) begin
      if (free_wrap) begin
        next_counter = wrap_value; // [RULE_15]
      end else begin
        next_counter = reload; // [RULE_02] [RULE_14]
      end
    end else if (plain_step) begin
      next_counter = stepped_value;
    end
    if (stopped_write) begin
      next_counter = count_write_data_i; // [RULE_07]
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      counter <= `TMA_CNT_ZERO; // [RULE_19]
    end else begin
      counter <= next_counter;
    end
  end

  // Reload register takes every write, running or not
  always_comb begin
    next_reload = reload;
    if (count_write_i) begin
      next_reload = count_write_data_i; // [RULE_07]
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reload <= `TMA_CNT_ZERO; // [RULE_19]
    end else begin
      reload <= next_reload;
    end
  end

  always_comb begin
    next_out_level = out_level;
    if (toggle_due) begin
      next_out_level = !out_level; // [RULE_09] [RULE_18]
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_level <= 1'b0;
    end else begin
      out_level <= next_out_level;
    end
  end

  // Interrupt pulse only on the cycle after a limit step
  always_comb begin
    next_irq = 1'b0;
    if (limit_step) begin
      next_irq = irq_allowed; // [RULE_05] [RULE_17] [RULE_21]
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq; // [RULE_22]
    end
  end

  assign count_read_data_o = counter; // [RULE_06]
  assign reload_value_o = reload;
  assign timer_output_pin_o = out_level;
  // The output pin turns input while it sets the count direction
  always_comb begin
    timer_output_pin_oe_o = pulse_output_enable_i; // [RULE_09]
    if (event_mode && direction_from_pin_i) begin
      timer_output_pin_oe_o = 1'b0; // [RULE_13]
    end
  end
  assign irq_o = irq;
  assign wrap_event_o = irq;
endmodule

/* File: tma_timer_channel_properties.sv */
// Checker of the timer channel port behaviour
`timescale 1ns/1ps
module tma_timer_channel_props #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic channel_run_flag_i,
  input wire logic [1:0] operating_mode_field_i,
  input wire logic pulse_output_enable_i,
  input wire logic count_write_i,
  input wire logic [WIDTH-1:0] count_write_data_i,
  input wire logic [WIDTH-1:0] count_read_data_o,
  input wire logic [WIDTH-1:0] reload_value_o,
  input wire logic timer_output_pin_o,
  input wire logic wrap_event_o,
  input wire logic irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_stop_wr;
    count_write_i && !channel_run_flag_i;
  endsequence
  sequence s_loaded;
    count_read_data_o == $past(count_write_data_i) && reload_value_o == $past(count_write_data_i);
  endsequence
  a_stop_write: assert property (s_stop_wr |=> s_loaded)
    else $error("stopped write not loaded");
  a_run_write: assert property (count_write_i && channel_run_flag_i |=>
    reload_value_o == $past(count_write_data_i)) else $error("running write lost");
  a_stop_holds: assert property (!channel_run_flag_i && !count_write_i |=>
    $stable(count_read_data_o)) else $error("counter moved while stopped");
  a_timer_reload: assert property (irq_o && $past(operating_mode_field_i) == 2'h0 &&
    !$past(count_write_i) |-> count_read_data_o == reload_value_o) else $error("no reload");
  a_irq_single: assert property (irq_o && $past(operating_mode_field_i) == 2'h0 |=>
    !irq_o) else $error("irq longer than one cycle");
  a_irq_wrap: assert property (wrap_event_o |-> $past(count_read_data_o) == 16'h0000 ||
    $past(count_read_data_o) == 16'hFFFF) else $error("wrap pulse without limit step");
  a_out_toggle: assert property (irq_o && $past(pulse_output_enable_i) |->
    timer_output_pin_o != $past(timer_output_pin_o)) else $error("output not toggled");
  a_zero_idle: assert property (count_read_data_o == 16'h0000 &&
    reload_value_o == 16'h0000 |=> !irq_o) else $error("irq with zero count");
endmodule
bind tma_timer_channel tma_timer_channel_props #(.WIDTH(WIDTH)) tma_timer_channel_props_inst (.*);

/* File: tma_timer_channel_tb_top.sv */
// Self-checking bench for the timer channel in timer and event counter modes
`timescale 1ns/1ps
module tma_timer_channel_tb_top;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, channel_run_flag_i = 1'b0, subclock_tick_i = 1'b1;
  logic [1:0] operating_mode_field_i = 2'h0, count_source_sel_i = 2'h0, event_source_sel_i = 2'h0;
  logic [3:0] prescale_divide_field_i = 4'h3;
  logic gate_enable_i = 1'b0, gate_active_high_i = 1'b1, pulse_output_enable_i = 1'b1;
  logic event_falling_edge_i = 1'b0, direction_from_pin_i = 1'b0, count_up_i = 1'b0;
  logic free_running_i = 1'b0, timer_input_pin_i = 1'b0, timer_output_pin_i = 1'b1;
  logic count_write_i = 1'b0, fire = 1'b0, t;
  logic [15:0] count_write_data_i = 16'h0000, count_read_data_o, reload_value_o, hold;
  logic timer_output_pin_o, timer_output_pin_oe_o, wrap_event_o, irq_o;
  logic other_group_event_i, prev_channel_event_i, next_channel_event_i;
  logic [1:0] srcs[6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h3};
  logic [3:0] pscs[6] = '{4'h3, 4'h3, 4'h3, 4'h0, 4'hF, 4'h3};
  logic [15:0] exps[6] = '{16'h0005, 16'h0028, 16'h001E, 16'h0005, 16'h0096, 16'h0140};
  int miscompares = 0, num_checks = 0, nirq = 0, c;
  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) subclock_tick_i <= #1 ~subclock_tick_i;
  always @(posedge sys_clk_i) if (irq_o === 1'b1) nirq <= nirq + 1;
  tma_timer_channel tma_timer_channel_inst (.*);
  tma_neighbour_model tma_neighbour_model_inst (.sys_clk_i, .rst_i, .fire_i(fire),
    .which_i(event_source_sel_i), .other_group_event_o(other_group_event_i),
    .prev_channel_event_o(prev_channel_event_i), .next_channel_event_o(next_channel_event_i));
  task tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task wr(input logic [15:0] v);
    count_write_i = 1'b1;
    count_write_data_i = v;
    tick(1);
    count_write_i = 1'b0;
  endtask
  // Cycles from one interrupt to the next, bounded
  task gap();
    c = 0;
    while (irq_o !== 1'b1 && c < 400) begin
      tick(1);
      c++;
    end
    c = 0;
    do begin
      tick(1);
      c++;
    end while (irq_o !== 1'b1 && c < 400);
  endtask
  task ev();
    if (event_source_sel_i == 2'h0) begin
      timer_input_pin_i = 1'b1;
      tick(3);
      timer_input_pin_i = 1'b0;
      tick(3);
    end else begin
      fire = 1'b1;
      tick(1);
      fire = 1'b0;
      tick(5);
    end
  endtask
  task give_verdict();
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    tick(20);
    rst_i = 1'b0;
    wr(16'h0002);
    chk("count", 16'h0002, count_read_data_o);
    chk("reload", 16'h0002, reload_value_o);
    channel_run_flag_i = 1'b1;
    gap();
    chk("period", 16'h0003, c[15:0]);
    chk("reloaded", 16'h0002, count_read_data_o);
    t = timer_output_pin_o;
    gap();
    chk("toggle", {15'h0000, ~t}, {15'h0000, timer_output_pin_o});
    chk("wrap", 16'h0001, {15'h0000, wrap_event_o});
    chk("pin oe", 16'h0001, {15'h0000, timer_output_pin_oe_o});
    wr(16'h0004);
    chk("reload", 16'h0004, reload_value_o);
    gap();
    chk("period", 16'h0005, c[15:0]);
    for (int i = 0; i < 6; i++) begin
      channel_run_flag_i = 1'b0;
      count_source_sel_i = srcs[i];
      prescale_divide_field_i = pscs[i];
      tick(1);
      channel_run_flag_i = 1'b1;
      gap();
      chk("source period", exps[i], c[15:0]);
    end
    count_source_sel_i = 2'h0;
    gate_enable_i = 1'b1;
    tick(3);
    hold = count_read_data_o;
    tick(10);
    chk("gated", hold, count_read_data_o);
    timer_input_pin_i = 1'b1;
    gap();
    chk("gate open", 16'h0005, c[15:0]);
    gate_enable_i = 1'b0;
    timer_input_pin_i = 1'b0;
    channel_run_flag_i = 1'b0;
    tick(1);
    wr(16'h0000);
    channel_run_flag_i = 1'b1;
    c = nirq;
    tick(20);
    chk("zero irqs", 16'h0000, 16'(nirq - c));
    operating_mode_field_i = 2'h1;
    for (int s = 0; s < 8; s++) begin
      channel_run_flag_i = 1'b0;
      event_source_sel_i = s[2:1];
      count_up_i = s[0];
      event_falling_edge_i = s[0];
      tick(1);
      wr(s[0] ? 16'hFFFD : 16'h0002);
      channel_run_flag_i = 1'b1;
      c = nirq;
      repeat (6) ev();
      chk("events", 16'h0002, 16'(nirq - c));
      chk("count", s[0] ? 16'hFFFD : 16'h0002, count_read_data_o);
    end
    channel_run_flag_i = 1'b0;
    free_running_i = 1'b1;
    direction_from_pin_i = 1'b1;
    count_up_i = 1'b0;
    tick(1);
    wr(16'hFFFE);
    channel_run_flag_i = 1'b1;
    c = nirq;
    repeat (3) ev();
    chk("free count", 16'h0001, count_read_data_o);
    chk("free irqs", 16'h0001, 16'(nirq - c));
    chk("pin oe", 16'h0000, {15'h0000, timer_output_pin_oe_o});
    timer_output_pin_i = 1'b0;
    c = nirq;
    repeat (2) ev();
    chk("pin down", 16'hFFFF, count_read_data_o);
    chk("down irqs", 16'h0001, 16'(nirq - c));
    give_verdict();
  end
  initial begin
    #500_000;
    miscompares++;
    give_verdict();
  end
endmodule
